// >>> bench/omc_debug_host.sv
`timescale 1ns/1ps
`default_nettype none

// debug host: one decoded command per call, then a scrambled bus
module omc_debug_host
   import omc_pkg::*;
(
   input wire logic sys_clk_i,
   output logic valid_o,
   output omc_cmd_type cmd_o
);
   initial begin
      valid_o = 1'h0;
      cmd_o = CMD_MEM_ACCESS;
   end
   // hold one cycle, then gap idle cycles (none when gap is zero)
   task automatic send(input omc_cmd_type c, input int gap);
      valid_o <= 1'h1;
      cmd_o <= c;
      @(posedge sys_clk_i);
      valid_o <= 1'h0;
      cmd_o <= omc_cmd_type'(~c);
      repeat (gap) @(posedge sys_clk_i);
   endtask : send
endmodule : omc_debug_host

`default_nettype wire

// >>> bench/omc_sva.sv
`timescale 1ns/1ps
`default_nettype none

// checks mode, clock gating and debug answers at the ports
module omc_sva
   import omc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic debug_cmd_valid_i,
   input wire omc_cmd_type debug_cmd_i,
   input wire logic background_halt_instruction_i,
   input wire logic irq_pending_i,
   input wire logic reset_pin_n_i,
   input wire logic irq_pin_n_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire omc_mode_type mode_o,
   input wire omc_power_type power_o,
   input wire logic cmd_accept_o,
   input wire logic cmd_execute_o,
   input wire logic cmd_error_o,
   input wire logic take_interrupt_o,
   input wire logic partial_powerdown_flag_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // software acknowledge of the powerdown flag
   wire logic ack_w;
   assign ack_w = reg_write_i && reg_addr_i == OMC_ACK_OFS && reg_wdata_i[OMC_PARTIAL_POWERDOWN_ACK_POS];
   // stop2 with both wakeup pins idle
   sequence s_stop2_quiet;
      (mode_o == MODE_STOP2 && reset_pin_n_i && irq_pin_n_i) [*4];
   endsequence
   // a debug command of a given class
   sequence s_cmd(omc_cmd_type c);
      debug_cmd_valid_i && debug_cmd_i == c;
   endsequence
   property p_bg_cmd;
      s_cmd(CMD_BACKGROUND) ##0 mode_o == MODE_RUN |=> cmd_accept_o;
   endproperty
   a_bg_cmd: assert property (p_bg_cmd) else $error("background command refused");
   property p_active_only;
      debug_cmd_valid_i && mode_o != MODE_BACKGROUND
         && debug_cmd_i inside {CMD_CPU_REG, CMD_TRACE, CMD_RESUME} |=> !cmd_execute_o;
   endproperty
   a_active_only: assert property (p_active_only) else $error("active command ran");
   property p_status_err;
      s_cmd(CMD_MEM_STATUS) ##0 mode_o inside {MODE_WAIT, MODE_STOP3}
         |=> cmd_error_o && !cmd_execute_o;
   endproperty
   a_status_err: assert property (p_status_err) else $error("status access ran");
   property p_halt;
      background_halt_instruction_i && mode_o == MODE_RUN |-> ##[1:2] mode_o == MODE_BACKGROUND;
   endproperty
   a_halt: assert property (p_halt) else $error("halt did not suspend");
   property p_bg_susp;
      mode_o inside {MODE_BACKGROUND, MODE_WAIT} |-> !power_o.cpu_clk_en;
   endproperty
   a_bg_susp: assert property (p_bg_susp) else $error("cpu clocked while held");
   property p_stop_clk;
      mode_o inside {MODE_STOP3, MODE_STOP2} |-> !power_o.cpu_clk_en && !power_o.bus_clk_en;
   endproperty
   a_stop_clk: assert property (p_stop_clk) else $error("clocks run in stop");
   property p_wait_irq;
      mode_o == MODE_WAIT && irq_pending_i && !debug_cmd_valid_i |-> ##[1:2] take_interrupt_o;
   endproperty
   a_wait_irq: assert property (p_wait_irq) else $error("wait not left on irq");
   property p_stop2_hold;
      s_stop2_quiet |=> mode_o == MODE_STOP2 && power_o.pin_latch && !power_o.regulator_full;
   endproperty
   a_stop2_hold: assert property (p_stop2_hold) else $error("stop2 left early");
   property p_flag_hold;
      partial_powerdown_flag_o && !ack_w && !$past(ack_w) |=> partial_powerdown_flag_o;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost early");
endmodule : omc_sva

bind omc_mode_ctrl omc_sva u_sva (.sys_clk_i, .reset_i, .debug_cmd_valid_i, .debug_cmd_i,
   .background_halt_instruction_i, .irq_pending_i, .reset_pin_n_i, .irq_pin_n_i, .reg_addr_i,
   .reg_wdata_i, .reg_write_i, .mode_o, .power_o, .cmd_accept_o, .cmd_execute_o, .cmd_error_o,
   .take_interrupt_o, .partial_powerdown_flag_o);

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// mode controller bench: drivers note answers, a monitor compares
module tb_top import omc_pkg::*; ;
   logic sys_clk_i = 1'h0;
   logic reset_i = 1'h1;
   logic debug_mode_select_pin_i = 1'h0; // strap low: background
   logic reset_pin_n_i = 1'h1;
   logic irq_pin_n_i = 1'h1;
   logic irq_pending_i = 1'h0;
   logic [6:0] evv = 7'h00; // halt, bp, trace bp, wait, stop, resume, force
   omc_wake_type wake_i = 8'h00;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_write_i = 1'h0;
   logic reg_read_i = 1'h0;
   logic debug_cmd_valid_i, cmd_accept_o, cmd_execute_o, cmd_error_o, partial_powerdown_flag_o;
   logic [3:0] pls; // clear mask, interrupt, reset vector, illegal
   logic [31:0] reg_rdata_o;
   omc_cmd_type debug_cmd_i;
   omc_mode_type mode_o;
   omc_power_type power_o;
   int fail_count = 0;
   int compares = 0;
   int seed = 37;
   logic [3:0] cmd_q[$]; // check error, accept, execute, error
   logic [31:0] rd_q[$];
   logic pc = 1'h0;
   logic pr = 1'h0;
   logic [3:0] e;
   logic [4:0] ctl[5] = '{5'h00, 5'h13, 5'h1D, 5'h05, 5'h11};
   omc_mode_type sm[5] = '{MODE_RUN, MODE_STOP3, MODE_STOP3, MODE_STOP3, MODE_STOP2};
   always #10 sys_clk_i = ~sys_clk_i;
   omc_debug_host host (.sys_clk_i, .valid_o(debug_cmd_valid_i), .cmd_o(debug_cmd_i));
   omc_mode_ctrl DUT (.sys_clk_i, .reset_i, .clk_en_i(1'h1), .debug_mode_select_pin_i,
      .reset_pin_n_i, .irq_pin_n_i, .debug_cmd_valid_i, .debug_cmd_i, .irq_pending_i, .wake_i,
      .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .mode_o, .power_o,
      .cmd_accept_o, .cmd_execute_o, .cmd_error_o, .partial_powerdown_flag_o,
      .background_halt_instruction_i(evv[0]),
      .debug_breakpoint_i(evv[1]), .trace_breakpoint_i(evv[2]), .wait_instruction_i(evv[3]),
      .stop_instruction_i(evv[4]), .resume_done_i(evv[5]), .debug_force_reset_i(evv[6]),
      .clear_int_mask_o(pls[0]), .take_interrupt_o(pls[1]), .take_reset_vector_o(pls[2]),
      .illegal_opcode_reset_o(pls[3]));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   // bounded waits, sampled at the falling edge
   task automatic wait_mode(input omc_mode_type m);
      for (int i = 0; i < 8; i++) begin
         @(negedge sys_clk_i);
         if (mode_o === m) break;
      end
      check("mode", mode_o, m);
      if (mode_o !== m) print_verdict();
   endtask : wait_mode
   task automatic wait_pulse(input int b);
      for (int i = 0; i < 8; i++) begin
         @(negedge sys_clk_i);
         if (pls[b] === 1'h1) break;
      end
      check("pulse", pls[b], 1'h1);
      if (pls[b] !== 1'h1) print_verdict();
   endtask : wait_pulse
   task automatic ev(input int k);
      @(posedge sys_clk_i);
      evv <= 7'h01 << k;
      @(posedge sys_clk_i);
      evv <= 7'h00;
   endtask : ev
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'h1;
      @(posedge sys_clk_i);
      reg_write_i <= 1'h0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] x);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'h1;
      rd_q.push_back(x);
      @(posedge sys_clk_i);
      reg_read_i <= 1'h0;
   endtask : reg_rd
   // expected answer of a command class in a mode
   function automatic logic [3:0] exp_cmd(input omc_cmd_type c, input omc_mode_type m);
      if (m == MODE_BACKGROUND) return 4'h6;
      if (m == MODE_RUN) return (c inside {CMD_CPU_REG, CMD_TRACE, CMD_RESUME}) ? 4'h0 : 4'h6;
      if (c == CMD_MEM_STATUS) return 4'hD;
      return (c == CMD_BACKGROUND) ? 4'h6 : 4'h0;
   endfunction : exp_cmd
   task automatic send_cmd(input omc_cmd_type c, input omc_mode_type m);
      @(posedge sys_clk_i);
      cmd_q.push_back(exp_cmd(c, m));
      host.send(c, 1);
   endtask : send_cmd
   task automatic cmds(input omc_mode_type m, input int n);
      omc_cmd_type c;
      repeat (n) begin
         c = omc_cmd_type'($unsigned($random(seed)) % 7);
         if (c == CMD_BACKGROUND && m != MODE_BACKGROUND) c = CMD_MEM_STATUS;
         send_cmd(c, m);
      end
   endtask : cmds
   // answer monitor: oldest note against the cycle after each request
   always @(posedge sys_clk_i) begin
      if (pc) begin
         e = cmd_q.pop_front();
         check("accept", cmd_accept_o, e[2]);
         check("execute", cmd_execute_o, e[1]);
         if (e[3]) check("error", cmd_error_o, e[0]);
      end
      if (pr) check("rdata", reg_rdata_o, rd_q.pop_front());
      pc = debug_cmd_valid_i;
      pr = reg_read_i;
   end
   initial begin
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'h0;
      reg_rd(OMC_CTRL_OFS, 32'h0);
      wait_mode(MODE_BACKGROUND);
      check("cpu clock", power_o.cpu_clk_en, 1'h0);
      cmds(MODE_BACKGROUND, 12);
      ev(5);
      wait_mode(MODE_RUN);
      cmds(MODE_RUN, 16);
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk_i);
         debug_mode_select_pin_i <= k[0];
         repeat (3) @(posedge sys_clk_i);
         ev(6);
         wait_mode(k ? MODE_RUN : MODE_BACKGROUND);
      end
      @(posedge sys_clk_i);
      reset_i <= 1'h1;
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'h0;
      repeat (3) @(posedge sys_clk_i);
      wait_mode(MODE_RUN);
      $display("test reset entry done");
      for (int k = 0; k < 4; k++) begin
         if (k < 3) ev(k);
         else send_cmd(CMD_BACKGROUND, MODE_RUN);
         wait_mode(MODE_BACKGROUND);
         ev(5);
         wait_mode(MODE_RUN);
      end
      $display("test background entry done");
      for (int k = 0; k < 2; k++) begin
         ev(3);
         wait_pulse(0);
         wait_mode(MODE_WAIT);
         check("cpu clock", power_o.cpu_clk_en, 1'h0);
         cmds(MODE_WAIT, 8);
         if (k == 0) begin
            @(posedge sys_clk_i);
            irq_pending_i <= 1'h1;
            wait_pulse(1);
            @(posedge sys_clk_i);
            irq_pending_i <= 1'h0;
         end else begin
            send_cmd(CMD_BACKGROUND, MODE_WAIT);
            wait_mode(MODE_BACKGROUND);
            ev(5);
         end
         wait_mode(MODE_RUN);
      end
      $display("test wait done");
      for (int k = 0; k < 5; k++) begin
         reg_wr(OMC_CTRL_OFS, {27'h0, ctl[k]});
         reg_rd(OMC_CTRL_OFS, {27'h0, ctl[k]});
         ev(4);
         if (k == 0) wait_pulse(3);
         wait_mode(sm[k]);
         check("clocks", {power_o.cpu_clk_en, power_o.bus_clk_en}, {2{k == 0}});
         check("debug clock", power_o.debug_clk_en, k < 2);
         check("regulator", power_o.regulator_full, k < 3);
         check("latch", {power_o.pin_latch, power_o.powerdown}, {2{k == 4}});
         repeat (5) @(posedge sys_clk_i);
         if (k == 1) begin
            send_cmd(CMD_MEM_STATUS, MODE_STOP3);
            send_cmd(CMD_BACKGROUND, MODE_STOP3);
            wait_mode(MODE_BACKGROUND);
            ev(5);
         end else if (k > 1) begin
            @(posedge sys_clk_i);
            if (k == 2) wake_i <= omc_wake_type'(8'h01 << ($unsigned($random(seed)) % 8));
            if (k == 3) reset_pin_n_i <= 1'h0;
            if (k == 4) irq_pin_n_i <= 1'h0;
            wait_pulse(k == 2 ? 1 : 2);
         end
         wait_mode(MODE_RUN);
         @(posedge sys_clk_i);
         wake_i <= 8'h00;
         reset_pin_n_i <= 1'h1;
         irq_pin_n_i <= 1'h1;
      end
      repeat (3) @(negedge sys_clk_i);
      check("flag", {partial_powerdown_flag_o, power_o.pin_latch}, 2'h3);
      reg_rd(OMC_STATUS_OFS, 32'h8);
      reg_wr(OMC_ACK_OFS, 32'h1);
      reg_rd(OMC_STATUS_OFS, 32'h0);
      reg_rd(4'hC, 32'h0);
      repeat (3) @(negedge sys_clk_i);
      check("flag", {partial_powerdown_flag_o, power_o.pin_latch}, 2'h0);
      $display("test stop done");
      print_verdict();
   end
endmodule : tb_top

`default_nettype wire

// >>> core/omc_mode_ctrl.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: debug pin low at reset enters background
// R2: debug command, halt instruction, breakpoints enter background
// R3: background suspends the cpu
// R4: non intrusive commands accepted run and background
// R5: cpu, trace, resume commands only in background
// R6: wait stops cpu clock, clears interrupt mask
// R7: interrupt leaves wait into service routine
// R8: wait accepts background and status access only
// R9: stop while disabled causes illegal opcode reset
// R10: debug enabled stop selects stop3, debug clocked
// R11: low voltage stop enabled selects stop3, regulator
// R12: otherwise powerdown select picks stop3 or stop2
// R13: every stop halts bus and cpu clock
// R14: stop3 keeps all state and pins
// R15: reset pin or listed interrupts leave stop3
// R16: stop3 exit: reset vector or interrupt vector
// R17: low voltage stop turns stop2 into stop3
// R18: software keeps low voltage on for analog
// R19: debug enabled keeps regulator full, no stop2
// R20: stop: status error, background wakes if enabled
// R21: stop2 powers down and latches pin controls
// R22: stop2 leaves only by reset or irq pin
// R23: stop2 wake sets flag until acknowledge written
// R24: debug pin high at reset enters run
// R25: one state machine, reset to run or background
module omc_mode_ctrl
   import omc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic debug_mode_select_pin_i,
   input wire logic reset_pin_n_i,
   input wire logic irq_pin_n_i,
   input wire logic debug_force_reset_i,
   input wire logic debug_cmd_valid_i,
   input wire omc_cmd_type debug_cmd_i,
   input wire logic background_halt_instruction_i,
   input wire logic wait_instruction_i,
   input wire logic stop_instruction_i,
   input wire logic debug_breakpoint_i,
   input wire logic trace_breakpoint_i,
   input wire logic resume_done_i,
   input wire logic irq_pending_i,
   input wire omc_wake_type wake_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [31:0] reg_rdata_o,
   output omc_mode_type mode_o,
   output omc_power_type power_o,
   output logic cmd_accept_o,
   output logic cmd_execute_o,
   output logic cmd_error_o,
   output logic clear_int_mask_o,
   output logic take_interrupt_o,
   output logic take_reset_vector_o,
   output logic illegal_opcode_reset_o,
   output logic partial_powerdown_flag_o
);

   // synchronised pins
   logic dbg_pin_s;
   logic rst_pin_n_s;
   logic irq_pin_n_s;

   // software control bits
   logic stop_instruction_enable_reg;
   logic debug_enable_bit_reg;
   logic low_voltage_detect_enable_reg;
   logic low_voltage_stop_enable_reg;
   logic partial_powerdown_select_reg;

   // mode state
   omc_mode_type mode_reg;
   omc_mode_type mode_next;
   logic init_done_reg;
   logic ppd_flag_reg;

   // helper terms
   logic lvd_stop;
   logic stop_wake;
   logic stop_ok;
   omc_mode_type stop_target;
   logic background_halt_instruction_cmd;
   logic ack_write;
   logic strap_load; // mode taken from the strap pin this cycle

   // pin synchronisers
   omc_sync #(
      .WIDTH(3)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .async_i({debug_mode_select_pin_i, reset_pin_n_i, irq_pin_n_i}),
      .sync_o({dbg_pin_s, rst_pin_n_s, irq_pin_n_s})
   );

   // low voltage detect enabled for stop
   assign lvd_stop = low_voltage_detect_enable_reg & low_voltage_stop_enable_reg;
   // stop instruction only honoured when enabled
   assign stop_ok = stop_instruction_enable_reg;
   // background command decode
   assign background_halt_instruction_cmd = debug_cmd_valid_i && (debug_cmd_i == CMD_BACKGROUND);
   // acknowledge write strobe
   assign ack_write = reg_write_i && (reg_addr_i == OMC_ACK_OFS)
                      && reg_wdata_i[OMC_PARTIAL_POWERDOWN_ACK_POS];
   // any stop3 interrupt source
   assign stop_wake = |wake_i;
   // strap is loaded on the first enabled edge after reset and on a forced reset
   assign strap_load = !init_done_reg || debug_force_reset_i;

   // stop mode selection from the control bits
   always_comb begin
      if (debug_enable_bit_reg) begin
         stop_target = MODE_STOP3; // R10 R19
      end else if (lvd_stop) begin
         stop_target = MODE_STOP3; // R11 R17
      end else if (partial_powerdown_select_reg) begin
         stop_target = MODE_STOP2; // R12
      end else begin
         stop_target = MODE_STOP3; // R12
      end
   end

   // control register writes
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         {partial_powerdown_select_reg, low_voltage_stop_enable_reg,
          low_voltage_detect_enable_reg, debug_enable_bit_reg,
          stop_instruction_enable_reg} <= OMC_CTRL_RESET;
      end else if (clk_en_i && reg_write_i && reg_addr_i == OMC_CTRL_OFS) begin
         stop_instruction_enable_reg <= reg_wdata_i[OMC_STOP_INSTRUCTION_ENABLE_POS];
         debug_enable_bit_reg <= reg_wdata_i[OMC_DBGEN_POS];
         low_voltage_detect_enable_reg <= reg_wdata_i[OMC_LOW_VOLTAGE_DETECT_ENABLE_POS];
         low_voltage_stop_enable_reg <= reg_wdata_i[OMC_LOW_VOLTAGE_STOP_ENABLE_POS];
         partial_powerdown_select_reg <= reg_wdata_i[OMC_PARTIAL_POWERDOWN_SELECT_POS];
      end
   end

   // next mode
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_RUN: begin
            // background events win over wait, wait over stop
            if (background_halt_instruction_cmd || background_halt_instruction_i
                || debug_breakpoint_i || trace_breakpoint_i) begin
               mode_next = MODE_BACKGROUND; // R2
            end else if (wait_instruction_i) begin
               mode_next = MODE_WAIT; // R6
            end else if (stop_instruction_i && stop_ok) begin
               mode_next = stop_target; // R10 R11 R12
            end
         end
         MODE_BACKGROUND: begin
            // cpu held until resume command completes
            if (resume_done_i) begin
               mode_next = MODE_RUN; // R3 R5
            end
         end
         MODE_WAIT: begin
            // background command wins over a pending interrupt
            if (background_halt_instruction_cmd) begin
               mode_next = MODE_BACKGROUND; // R8
            end else if (irq_pending_i) begin
               mode_next = MODE_RUN; // R7
            end
         end
         MODE_STOP3: begin
            // wake sources and the reset pin win over a background command
            if (!rst_pin_n_s || stop_wake) begin
               mode_next = MODE_RUN; // R15 R16
            end else if (background_halt_instruction_cmd && debug_enable_bit_reg) begin
               mode_next = MODE_BACKGROUND; // R20
            end
         end
         MODE_STOP2: begin
            // only the two wakeup pins or a forced reset end stop2
            if (!rst_pin_n_s || !irq_pin_n_s) begin
               mode_next = MODE_RUN; // R22
            end
         end
         default: begin
            // unused codes fall back to run
            mode_next = MODE_RUN;
         end
      endcase
      // a strap load overrides every event of the cycle
      if (strap_load) begin
         mode_next = dbg_pin_s ? MODE_RUN : MODE_BACKGROUND; // R1 R24
      end
   end

   // mode state machine
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mode_reg <= MODE_RUN; // R25
         init_done_reg <= 1'b0;
      end else if (clk_en_i) begin
         init_done_reg <= 1'b1;
         // strap loads already sit in the next mode, so outputs follow at once
         mode_reg <= mode_next;
      end
   end

   // partial powerdown flag: set on stop2 wake, cleared by acknowledge
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ppd_flag_reg <= 1'b0;
      end else if (clk_en_i) begin
         // set wins over an acknowledge in the same cycle
         if (mode_reg == MODE_STOP2 && mode_next == MODE_RUN) begin
            ppd_flag_reg <= 1'b1; // R23
         end else if (ack_write) begin
            ppd_flag_reg <= 1'b0; // R23
         end
      end
   end

   // debug command filtering per mode
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cmd_accept_o <= 1'b0;
         cmd_execute_o <= 1'b0;
         cmd_error_o <= 1'b0;
      end else if (clk_en_i) begin
         cmd_accept_o <= 1'b0;
         cmd_execute_o <= 1'b0;
         cmd_error_o <= 1'b0;
         if (debug_cmd_valid_i) begin
            case (mode_reg)
               MODE_RUN: begin
                  // only non intrusive commands run
                  cmd_accept_o <= debug_cmd_i inside {CMD_MEM_ACCESS, CMD_MEM_STATUS,
                     CMD_REG_ACCESS, CMD_BACKGROUND}; // R4
                  cmd_execute_o <= debug_cmd_i inside {CMD_MEM_ACCESS, CMD_MEM_STATUS,
                     CMD_REG_ACCESS, CMD_BACKGROUND}; // R4
               end
               MODE_BACKGROUND: begin
                  cmd_accept_o <= 1'b1; // R4 R5
                  cmd_execute_o <= 1'b1; // R5
               end
               MODE_WAIT, MODE_STOP3, MODE_STOP2: begin
                  // status access reports stop or wait without memory access
                  cmd_accept_o <= debug_cmd_i inside {CMD_MEM_STATUS,
                     CMD_BACKGROUND}; // R8 R20
                  cmd_error_o <= debug_cmd_i == CMD_MEM_STATUS; // R8 R20
                  cmd_execute_o <= background_halt_instruction_cmd && (mode_reg == MODE_WAIT
                     || debug_enable_bit_reg); // R8 R20
               end
               default: begin
                  cmd_accept_o <= 1'b0;
               end
            endcase
         end
      end
   end

   // cpu side event pulses
   // each pulse but the illegal opcode reset marks a single mode change; that one marks a refused stop while run stays run
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         clear_int_mask_o <= 1'b0;
         take_interrupt_o <= 1'b0;
         take_reset_vector_o <= 1'b0;
         illegal_opcode_reset_o <= 1'b0;
      end else if (clk_en_i) begin
         clear_int_mask_o <= mode_reg == MODE_RUN && mode_next == MODE_WAIT; // R6
         take_interrupt_o <= (mode_reg == MODE_WAIT && mode_next == MODE_RUN) // R7
            || (mode_reg == MODE_STOP3 && mode_next == MODE_RUN && rst_pin_n_s); // R16
         take_reset_vector_o <= (mode_reg == MODE_STOP3 && !rst_pin_n_s)
            || (mode_reg == MODE_STOP2 && mode_next == MODE_RUN); // R16
         illegal_opcode_reset_o <= mode_reg == MODE_RUN && mode_next == MODE_RUN
            && stop_instruction_i && !stop_ok; // R9
      end
   end

   // clock gating and power outputs follow the next mode; the pin latch is also held while the powerdown flag is set
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mode_o <= MODE_RUN;
         power_o <= '{cpu_clk_en: 1'b1, bus_clk_en: 1'b1, debug_clk_en: 1'b1,
                      regulator_full: 1'b1, pin_latch: 1'b0, powerdown: 1'b0};
      end else if (clk_en_i) begin
         mode_o <= mode_next;
         // cpu halted in background, wait and stop; bus halted only in stop
         power_o.cpu_clk_en <= mode_next == MODE_RUN; // R3 R6 R13
         power_o.bus_clk_en <= !(mode_next inside {MODE_STOP3, MODE_STOP2}); // R13
         power_o.debug_clk_en <= !(mode_next inside {MODE_STOP3, MODE_STOP2})
            || debug_enable_bit_reg; // R10 R19
         power_o.regulator_full <= !(mode_next inside {MODE_STOP3, MODE_STOP2})
            || debug_enable_bit_reg || lvd_stop; // R11 R17 R19
         // stop3 keeps everything; stop2 powers down and latches pins
         power_o.powerdown <= mode_next == MODE_STOP2; // R14 R21
         power_o.pin_latch <= mode_next == MODE_STOP2
            || (ppd_flag_reg && !ack_write)
            || (mode_reg == MODE_STOP2 && mode_next == MODE_RUN); // R21 R23
      end
   end

   // register read port, data one cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (clk_en_i) begin
         reg_rdata_o <= 32'h0000_0000;
         if (reg_read_i) begin
            case (reg_addr_i)
               OMC_CTRL_OFS: begin
                  // control bits at their field positions
                  reg_rdata_o <= {27'h0000000, partial_powerdown_select_reg,
                     low_voltage_stop_enable_reg, low_voltage_detect_enable_reg,
                     debug_enable_bit_reg, stop_instruction_enable_reg};
               end
               OMC_STATUS_OFS: begin
                  // powerdown flag above the current mode code
                  reg_rdata_o <= {28'h0000000, ppd_flag_reg, mode_reg};
               end
               default: begin
                  reg_rdata_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // flag output
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         partial_powerdown_flag_o <= 1'b0;
      end else if (clk_en_i) begin
         partial_powerdown_flag_o <= ppd_flag_reg;
      end
   end

endmodule : omc_mode_ctrl

`default_nettype wire

// >>> core/omc_pkg.sv
package omc_pkg;

   // operating modes of the controller
   typedef enum logic [2:0] {
      MODE_RUN,
      MODE_BACKGROUND,
      MODE_WAIT,
      MODE_STOP3,
      MODE_STOP2
   } omc_mode_type;

   // debug command classes as decoded by the serial debug front end
   typedef enum logic [2:0] {
      CMD_MEM_ACCESS,
      CMD_MEM_STATUS,
      CMD_REG_ACCESS,
      CMD_BACKGROUND,
      CMD_CPU_REG,
      CMD_TRACE,
      CMD_RESUME
   } omc_cmd_type;

   // register offsets
   localparam logic [3:0] OMC_CTRL_OFS = 4'h0;
   localparam logic [3:0] OMC_STATUS_OFS = 4'h4;
   localparam logic [3:0] OMC_ACK_OFS = 4'h8;

   // control register field positions
   localparam int OMC_STOP_INSTRUCTION_ENABLE_POS = 0;
   localparam int OMC_DBGEN_POS = 1;
   localparam int OMC_LOW_VOLTAGE_DETECT_ENABLE_POS = 2;
   localparam int OMC_LOW_VOLTAGE_STOP_ENABLE_POS = 3;
   localparam int OMC_PARTIAL_POWERDOWN_SELECT_POS = 4;
   // acknowledge register field position
   localparam int OMC_PARTIAL_POWERDOWN_ACK_POS = 0;

   // reset value of the control register
   localparam logic [4:0] OMC_CTRL_RESET = 5'h00;

   // two stage pin synchroniser depth
   localparam int OMC_SYNC_STAGES = 2;

   // wakeup source grouping for stop3
   typedef struct packed {
      logic rtc;
      logic usb_resume;
      logic low_voltage;
      logic converter;
      logic ext_irq;
      logic keyboard;
      logic serial;
      logic comparator;
   } omc_wake_type;

   // clock and power controls toward the chip
   typedef struct packed {
      logic cpu_clk_en;
      logic bus_clk_en;
      logic debug_clk_en;
      logic regulator_full;
      logic pin_latch;
      logic powerdown;
   } omc_power_type;

endpackage : omc_pkg

// >>> core/omc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two flip-flop synchroniser for asynchronous pins
module omc_sync
   import omc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   // first stage, read only by the second stage
   logic [WIDTH-1:0] meta_reg;

   // both stages keep sampling through reset, so the strap and the idle high
   // pins are settled at release and no false wakeup follows it
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || clk_en_i) begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end

endmodule : omc_sync

`default_nettype wire
